//--- rtl/mbs_defs.vh
// Constants for the Modbus slave register front end
`ifndef MBS_DEFS_VH
`define MBS_DEFS_VH
`define MBS_FC_READ_HOLD    8'h03
`define MBS_FC_WRITE_SINGLE 8'h06
`define MBS_ADDR_MEAS_INT   16'h0020
`define MBS_ADDR_SETPOINT   16'h0021
`define MBS_ADDR_MEAS_FLT   16'hA100
`define MBS_ADDR_MEAS_FLT1  16'hA101
`define MBS_FULL_SCALE      16'h7D00
`define MBS_SETPOINT_RESET  16'h0000
`define MBS_EXC_FLAG        8'h80
`define MBS_EXC_ILL_FUNC    8'h01
`define MBS_EXC_ILL_ADDR    8'h02
`define MBS_EXC_ILL_VALUE   8'h03
`define MBS_CRC_INIT        16'hFFFF
`define MBS_CRC_POLY        16'hA001
`define MBS_MAX_QTY         16'h007D
`endif

//--- rtl/mbs_crc16.v
// Modbus CRC-16 accumulator, one byte per cycle
`timescale 1ns/1ns
`default_nettype none
`include "mbs_defs.vh"
module mbs_crc16 (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Control
  input  wire        clear,
  input  wire        byteValid,
  input  wire [7:0]  byteIn,
  // Result
  output reg  [15:0] crc
);
  wire [15:0] stage [0:8];
  // Clear with a byte in one cycle: byte starts a fresh sum
  assign stage[0] = (clear ? `MBS_CRC_INIT : crc) ^ {8'h00, byteIn};
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gBit
      assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ `MBS_CRC_POLY) : (stage[i] >> 1);
    end
  endgenerate
  always @(posedge clk or posedge reset) begin
    if (reset)
      crc <= `MBS_CRC_INIT;
    else if (byteValid)
      crc <= stage[8];
    else if (clear)
      crc <= `MBS_CRC_INIT;
  end
endmodule // mbs_crc16
`default_nettype wire

//--- rtl/mbs_slave.v
// Modbus RTU slave register front end: frame parser, register map, responder
// Summary of operation
// - Read reply: address, function, count, data, CRC
// - Byte count equals twice register quantity
// - Integer measured value at 0x0020
// - Integer measured value full scale 32000
// - Float measured value read-only at 0xA100
// - Float measured value IEEE-754 single, four bytes
// - Setpoint read/write register at 0x0021
// - Setpoint 32000 means 100 percent
// - Device appends own CRC to responses
// - Write single setpoint: store, echo request
`timescale 1ns/1ns
`default_nettype none
`include "mbs_defs.vh"
module mbs_slave (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Configuration
  input  wire [7:0]  slaveAddr,
  // Instrument values
  input  wire [15:0] measIn,
  input  wire [31:0] measFloatIn,
  // Received bytes
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        rxFrameEnd,
  // Transmitted bytes
  output wire        txValid,
  output reg  [7:0]  txData,
  input  wire        txReady,
  output reg         txFrameEnd,
  // Status
  output reg  [15:0] setpoint,
  output reg         crcError
);
  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam ST_RX   = 2'd0;
  localparam ST_SKIP = 2'd1;
  localparam ST_TX   = 2'd2;
  localparam ST_CRC  = 2'd3;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register read mux; also tells if address is mapped
  function [16:0] regRead;
    input [15:0] addr;
    input [15:0] meas;
    input [31:0] measF;
    input [15:0] sp;
    begin
      case (addr)
        `MBS_ADDR_MEAS_INT:  regRead = {1'b1, meas};
        `MBS_ADDR_SETPOINT:  regRead = {1'b1, sp};
        `MBS_ADDR_MEAS_FLT:  regRead = {1'b1, measF[31:16]};
        `MBS_ADDR_MEAS_FLT1: regRead = {1'b1, measF[15:0]};
        default:             regRead = 17'h00000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Receive and transmit side
  // ----------------------------------------------------------------
  reg  [1:0]  state;
  reg  [7:0]  rxBuf [0:7];
  reg  [3:0]  rxCount;
  reg  [7:0]  txBuf [0:7];
  reg  [3:0]  txLen;
  reg  [3:0]  txIdx;
  reg  [15:0] rdAddr;
  reg  [7:0]  rdLeft;
  reg         rdHigh;
  reg  [15:0] rdWord;
  reg         crcClear;
  wire [15:0] crcVal;
  wire        crcFeed;
  wire [7:0]  crcByte;
  integer     k;

  wire [15:0] reqAddr = {rxBuf[2], rxBuf[3]};
  wire [15:0] reqVal  = {rxBuf[4], rxBuf[5]};
  wire        rxCrcOk = (crcVal == 16'h0000);
  wire [16:0] mapA    = regRead(reqAddr, measIn, measFloatIn, setpoint);
  wire [15:0] reqLast = reqAddr + reqVal - 16'h0001;
  wire [16:0] mapB    = regRead(reqLast, measIn, measFloatIn, setpoint);
  wire [16:0] curWord = regRead(rdAddr, measIn, measFloatIn, setpoint);
  wire [16:0] nextWord = regRead(rdAddr + 16'h0001, measIn, measFloatIn, setpoint);
  wire [15:0] fltBase = `MBS_ADDR_MEAS_FLT;
  wire        isFlt   = (reqAddr[15:8] == fltBase[15:8]);
  wire        addrMatch = (rxBuf[0] == slaveAddr);

  assign txValid = (state == ST_TX) || (state == ST_CRC);
  wire   txFire  = txValid && txReady;
  wire   inData  = (state == ST_TX) && (txIdx >= txLen);
  assign crcFeed = (state == ST_RX) ? (rxValid && rxCount < 4'd8) :
                   ((state == ST_TX) && txFire);
  assign crcByte = (state == ST_RX) ? rxData : txData;

  mbs_crc16 uCrc (
    .clk       (clk),
    .reset     (reset),
    .clear     (crcClear),
    .byteValid (crcFeed),
    .byteIn    (crcByte),
    .crc       (crcVal)
  );

  // Output byte selection
  always @* begin
    if (state == ST_CRC)
      txData = txIdx[0] ? crcVal[15:8] : crcVal[7:0];
    else if (inData)
      txData = rdHigh ? rdWord[15:8] : rdWord[7:0];
    else
      txData = txBuf[txIdx[2:0]];
  end

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= ST_RX;
      rxCount    <= 4'd0;
      txLen      <= 4'd0;
      txIdx      <= 4'd0;
      rdAddr     <= 16'h0000;
      rdLeft     <= 8'h00;
      rdHigh     <= 1'b1;
      rdWord     <= 16'h0000;
      crcClear   <= 1'b1;
      setpoint   <= `MBS_SETPOINT_RESET;
      crcError   <= 1'b0;
      txFrameEnd <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        rxBuf[k] <= 8'h00;
        txBuf[k] <= 8'h00;
      end
    end else begin
      crcClear   <= 1'b0;
      txFrameEnd <= 1'b0;
      case (state)
        ST_RX: begin
          if (rxValid && rxCount < 4'd8) begin
            rxBuf[rxCount[2:0]] <= rxData;
            rxCount <= rxCount + 4'd1;
          end
          if (rxFrameEnd) begin
            rxCount  <= 4'd0;
            crcClear <= 1'b1;
            crcError <= (rxCount == 4'd8) && !rxCrcOk;
            state    <= ST_RX;
            txBuf[0] <= rxBuf[0];
            txBuf[1] <= rxBuf[1];
            txIdx    <= 4'd0;
            if (rxCount == 4'd8 && rxCrcOk && addrMatch) begin
              state <= ST_SKIP;
              if (rxBuf[1] == `MBS_FC_READ_HOLD) begin
                if (reqVal == 16'h0000 || reqVal > `MBS_MAX_QTY) begin
                  txBuf[1] <= rxBuf[1] | `MBS_EXC_FLAG;
                  txBuf[2] <= `MBS_EXC_ILL_VALUE;
                  txLen    <= 4'd3;
                end else if (!mapA[16] || !mapB[16] ||
                             (isFlt != ((reqAddr + reqVal - 16'h0001) >> 8 == 
                                        `MBS_ADDR_MEAS_FLT >> 8))) begin
                  txBuf[1] <= rxBuf[1] | `MBS_EXC_FLAG;
                  txBuf[2] <= `MBS_EXC_ILL_ADDR;
                  txLen    <= 4'd3;
                end else begin
                  txBuf[2] <= {reqVal[6:0], 1'b0};
                  txLen    <= 4'd3;
                  rdAddr   <= reqAddr;
                  rdLeft   <= reqVal[7:0];
                  rdHigh   <= 1'b1;
                end
              end else if (rxBuf[1] == `MBS_FC_WRITE_SINGLE) begin
                if (reqAddr == `MBS_ADDR_SETPOINT) begin
                  setpoint <= reqVal;
                  for (k = 2; k < 6; k = k + 1)
                    txBuf[k] <= rxBuf[k];
                  txLen <= 4'd6;
                end else begin
                  txBuf[1] <= rxBuf[1] | `MBS_EXC_FLAG;
                  txBuf[2] <= `MBS_EXC_ILL_ADDR;
                  txLen    <= 4'd3;
                end
              end else begin
                txBuf[1] <= rxBuf[1] | `MBS_EXC_FLAG;
                txBuf[2] <= `MBS_EXC_ILL_FUNC;
                txLen    <= 4'd3;
              end
            end
          end
        end
        ST_SKIP: begin
          // Fresh CRC for the response
          rdWord <= curWord[15:0];
          rdLeft <= (txBuf[1] == `MBS_FC_READ_HOLD) ? rdLeft : 8'h00;
          state  <= ST_TX;
        end
        ST_TX: begin
          if (txFire) begin
            if (!inData) begin
              txIdx <= txIdx + 4'd1;
              if (txIdx + 4'd1 >= txLen && rdLeft == 8'h00) begin
                state <= ST_CRC;
                txIdx <= 4'd0;
              end
            end else if (rdHigh) begin
              rdHigh <= 1'b0;
            end else begin
              rdHigh <= 1'b1;
              rdLeft <= rdLeft - 8'h01;
              rdAddr <= rdAddr + 16'h0001;
              rdWord <= nextWord[15:0];
              if (rdLeft == 8'h01) begin
                state <= ST_CRC;
                txIdx <= 4'd0;
              end
            end
          end
        end
        ST_CRC: begin
          if (txFire) begin
            txIdx <= txIdx + 4'd1;
            if (txIdx[0]) begin
              state      <= ST_RX;
              crcClear   <= 1'b1;
              txFrameEnd <= 1'b1;
              txIdx      <= 4'd0;
            end
          end
        end
        default: state <= ST_RX;
      endcase
    end
  end
endmodule // mbs_slave
`default_nettype wire

//--- sim/mbs_slave_properties.sv
// Concurrent checks on the slave's ports
`timescale 1ns/1ns
`default_nettype none
module mbs_slave_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Request side
  input wire logic [7:0]  slaveAddr,
  input wire logic        rxFrameEnd,
  // Response side
  input wire logic        txValid,
  input wire logic [7:0]  txData,
  input wire logic        txReady,
  input wire logic        txFrameEnd,
  // Status
  input wire logic [15:0] setpoint,
  input wire logic        crcError
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wait; txValid && !txReady; endsequence
  sequence s_take; txValid && txReady; endsequence
  hold_byte_a: assert property (s_wait |=> txValid && $stable(txData))
    else $error("tx byte changed before accept");
  reply_delay_a: assert property ($rose(txValid) |-> $past(rxFrameEnd, 2))
    else $error("reply not two cycles after frame end");
  reply_addr_a: assert property ($rose(txValid) |-> txData == slaveAddr)
    else $error("reply does not start with own address");
  frame_end_a: assert property (txFrameEnd |-> $past(txValid && txReady) && !txValid)
    else $error("frame end without final accept");
  end_pulse_a: assert property (s_take ##1 txFrameEnd |=> !txFrameEnd)
    else $error("frame end longer than one cycle");
  tx_done_a: assert property ($rose(txValid) |-> ##[1:1000] txFrameEnd)
    else $error("reply never finished");
  sp_write_a: assert property ($changed(setpoint) |-> $past(rxFrameEnd))
    else $error("setpoint changed outside frame end");
  crc_flag_a: assert property ($changed(crcError) |-> $past(rxFrameEnd))
    else $error("crc flag changed outside frame end");
  bad_crc_quiet_a: assert property (crcError |-> !txValid)
    else $error("reply sent after bad crc frame");
endmodule // mbs_slave_properties
bind mbs_slave mbs_slave_properties u_chk (.clk(clk), .reset(reset), .slaveAddr(slaveAddr),
  .rxFrameEnd(rxFrameEnd), .txValid(txValid), .txData(txData), .txReady(txReady),
  .txFrameEnd(txFrameEnd), .setpoint(setpoint), .crcError(crcError));
`default_nettype wire

//--- sim/mbs_master_model.sv
// Bus master model: sends framed requests, collects replies
`timescale 1ns/1ns
`default_nettype none
module mbs_master_model (
  // Clock
  input wire logic       clk,
  // Request bytes
  output logic           rxValid,
  output logic     [7:0] rxData,
  output logic           rxFrameEnd,
  // Reply bytes
  input wire logic       txValid,
  input wire logic [7:0] txData,
  input wire logic       txFrameEnd,
  output logic           txReady
);
  typedef logic [7:0] mbs_bq_t[$];
  initial begin
    rxValid = 0; rxData = 8'h00; rxFrameEnd = 0; txReady = 0;
  end
  function automatic logic [15:0] crc(input mbs_bq_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic xfer(input mbs_bq_t q, input bit bad, slow, output mbs_bq_t r);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    r = {};
    foreach (q[i]) begin
      @(negedge clk); rxValid = 1; rxData = q[i];
    end
    @(negedge clk); rxValid = 0; rxData = ~rxData; rxFrameEnd = 1;
    @(negedge clk); rxFrameEnd = 0;
    for (int n = 0; n < 80; n++) begin
      @(negedge clk);
      if (txFrameEnd) break;
      txReady = slow ? ~txReady : 1'b1;
      if (txValid && txReady) r.push_back(txData);
    end
  endtask
endmodule // mbs_master_model
`default_nettype wire

//--- sim/tb_mbs_slave.sv
// Self-checking bench for the slave register front end
`timescale 1ns/1ns
`default_nettype none
module tb_mbs_slave;
  typedef logic [7:0] mbs_bq_t[$];
  logic clk = 0, reset = 1;
  logic [15:0] measIn = 16'h7D00;
  logic [31:0] measFloatIn = 32'h425C0000;
  wire rxValid, rxFrameEnd, txValid, txReady, txFrameEnd, crcError;
  wire [7:0] rxData, txData;
  wire [15:0] setpoint;
  int err_total = 0, cmp_count = 0;
  mbs_bq_t none;
  always #50 clk = ~clk;
  mbs_slave u_dut (.clk(clk), .reset(reset), .slaveAddr(8'h01), .measIn(measIn),
    .measFloatIn(measFloatIn), .rxValid(rxValid), .rxData(rxData), .rxFrameEnd(rxFrameEnd),
    .txValid(txValid), .txData(txData), .txReady(txReady), .txFrameEnd(txFrameEnd),
    .setpoint(setpoint), .crcError(crcError));
  mbs_master_model u_mst (.clk(clk), .rxValid(rxValid), .rxData(rxData),
    .rxFrameEnd(rxFrameEnd), .txValid(txValid), .txData(txData),
    .txFrameEnd(txFrameEnd), .txReady(txReady));
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input mbs_bq_t q, input bit bad, slow, input mbs_bq_t e);
    mbs_bq_t r;
    logic [15:0] c;
    u_mst.xfer(q, bad, slow, r);
    if (e.size() > 0) begin
      c = u_mst.crc(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    chk(r.size(), e.size());
    foreach (e[i]) if (i < r.size()) chk(r[i], e[i]);
  endtask
  task final_report;
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    reset = 0;
    run({8'h01,8'h03,8'h00,8'h20,8'h00,8'h01}, 0, 0, {8'h01,8'h03,8'h02,8'h7D,8'h00});
    run({8'h01,8'h06,8'h00,8'h21,8'h7D,8'h00}, 0, 0, {8'h01,8'h06,8'h00,8'h21,8'h7D,8'h00});
    chk(setpoint, 16'h7D00);
    run({8'h01,8'h03,8'h00,8'h21,8'h00,8'h01}, 0, 1, {8'h01,8'h03,8'h02,8'h7D,8'h00});
    run({8'h01,8'h03,8'hA1,8'h00,8'h00,8'h02}, 0, 1, {8'h01,8'h03,8'h04,8'h42,8'h5C,8'h00,8'h00});
    measIn = 16'h1234;
    run({8'h01,8'h03,8'h00,8'h20,8'h00,8'h02}, 0, 0, {8'h01,8'h03,8'h04,8'h12,8'h34,8'h7D,8'h00});
    run({8'h01,8'h06,8'hA1,8'h00,8'h00,8'h00}, 0, 0, {8'h01,8'h86,8'h02});
    run({8'h01,8'h03,8'h00,8'h22,8'h00,8'h01}, 0, 0, {8'h01,8'h83,8'h02});
    run({8'h01,8'h03,8'h00,8'h20,8'h00,8'h00}, 0, 0, {8'h01,8'h83,8'h03});
    run({8'h01,8'h04,8'h00,8'h20,8'h00,8'h01}, 0, 0, {8'h01,8'h84,8'h01});
    run({8'h01,8'h06,8'h00,8'h21,8'h00,8'h00}, 1, 0, none);
    chk(crcError, 1'b1);
    run({8'h02,8'h06,8'h00,8'h21,8'h00,8'h00}, 0, 0, none);
    chk(setpoint, 16'h7D00);
    chk(crcError, 1'b0);
    chk(u_mst.crc({8'h01,8'h03,8'h02,8'h7D,8'h00}), 16'h1499);
    chk(u_mst.crc({8'h01,8'h03,8'h00,8'h20,8'h00,8'h01}), 16'hC085);
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    chk(setpoint, 16'h0000);
    run({8'h01,8'h03,8'h00,8'h21,8'h00,8'h01}, 0, 0, {8'h01,8'h03,8'h02,8'h00,8'h00});
    final_report;
  end
  initial begin
    #500000;
    err_total++;
    final_report;
  end
endmodule // tb_mbs_slave
`default_nettype wire
